// [verilog/uart_feature_regs.svh]
// Register map, field positions, reset values and timing counts for the feature controller.
// Assumes a 32-bit AHB-Lite bus; each 8-bit register sits in the low byte of an aligned word.
`ifndef UART_FEATURE_REGS_SVH
`define UART_FEATURE_REGS_SVH

`define NCFG 11
`define A_IER 8'h00
`define A_MCR 8'h0C
`define A_DELAY 8'h2C
`define A_FC2 8'h30
`define A_FC1 8'h34
`define A_ISR 8'h38
`define A_LSR 8'h3C
`define A_MSR 8'h40
`define A_TXFILL 8'h44
`define A_RXFILL 8'h48
`define IDX_IER 4'h0
`define IDX_MCR 4'h3
`define IER_TXE 1
`define MCR_DTR 0
`define MCR_RTS 1
`define FC2_MD 0
`define FC2_RXOFF 1
`define FC2_TXOFF 2
`define FC2_SEL 3
`define FC2_TXDIR 4
`define FC2_INV 5
`define FC2_MASK 8'h3F
`define FC1_TXE 0
`define FC1_SRST 1
`define FC1_REMAP 2
`define FC1_SLP 4
`define FC1_MASK 8'h15
`define ISR_RST 8'h01
`define ISR_TXE 8'h02
`define LSR_RST 2'h3
`define SRST_CYC 3'h4

`endif

// [verilog/uart_feature_pkg.sv]
// Types shared by the feature controller and its bench.
// Assumes the register header is on the include path.
`include "uart_feature_regs.svh"
package uart_feature_pkg;

   typedef enum logic [1:0] {DIR_RX, DIR_TX, DIR_HOLD} dir_t;

   // Asynchronous line-side inputs, all synchronised before use
   typedef struct packed {
      logic rx;
      logic cd_n;
      logic ri_n;
      logic dsr_n;
      logic cts_n;
   } pins_t;

   // Transmit datapath status, same clock domain
   typedef struct packed {
      logic tx_pending;
      logic tx_done;
      logic bit_tick;
      logic tsr_empty;
      logic fifo_empty;
      logic below_trig;
   } tx_stat_t;

   typedef struct packed {
      logic [`NCFG-1:0][7:0] cfg;
      logic [7:0] delay;
      logic [7:0] fc2;
      logic [7:0] fc1;
      logic [2:0] srst_cnt;
      dir_t dir;
      logic [7:0] cnt;
      logic sleeping;
      logic rx_prev;
      logic primed;
      logic [3:0] msr_hi;
      logic [3:0] msr_lo;
      logic [1:0] lsr65;
      logic int_o;
      logic irq_n_oe;
      logic txd;
      logic rts_n;
      logic dtr_n;
      logic flow_ok;
      logic tx_go;
      logic rx_on;
      logic multidrop;
      logic uart_rst_n;
      logic hreadyout;
      logic [31:0] hrdata;
      logic wr_pend;
      logic [7:0] wr_addr;
   } state_t;

endpackage

// [verilog/sync2.sv]
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes the destination clock is hclk; the first stage feeds only the second.
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// [verilog/uart_feature_ctrl.sv]
// Feature control of a single UART: multidrop direction turn-around, tx/rx disable,
// sleep sensitivity, flow-control remap, transmit-empty interrupt mode, soft reset.
// Assumes an AHB-Lite master on hclk, a transmit datapath reporting on tx_stat,
// and asynchronous line pins that are synchronised here.
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "uart_feature_regs.svh"
module uart_feature_ctrl (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire uart_feature_pkg::pins_t pins,
   input wire uart_feature_pkg::tx_stat_t tx_stat,
   input wire logic tx_serial,
   input wire logic sleep_req,
   input wire logic [7:0] tx_fill,
   input wire logic [7:0] rx_fill,
   output logic txd,
   output logic rts_n,
   output logic dtr_n,
   output logic int_o,
   output logic irq_n_o,
   output logic irq_n_oe,
   output logic tx_go,
   output logic rx_on,
   output logic multidrop,
   output logic flow_ok,
   output logic sleeping,
   output logic uart_rst_n
);
   import uart_feature_pkg::*;

   localparam state_t RST_S = '{dir: DIR_RX, lsr65: `LSR_RST, txd: 1'b1, rts_n: 1'b1,
      dtr_n: 1'b1, rx_on: 1'b1, hreadyout: 1'b1, default: '0};

   state_t s_reg;
   state_t s_next;
   pins_t sp;
   logic rx;
   logic [3:0] modem;
   logic addr_ok;
   logic [7:0] a;
   logic [7:0] rb;
   logic [7:0] wd;
   logic msr_rd;
   logic dir_en;
   logic lvl;
   logic txe;
   logic pend;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   sync2 #(.W(5)) u_sync (
      .clk(hclk),
      .rst_n(hresetn),
      .d(pins),
      .q(sp)
   );

   assign rx = sp.rx;
   assign modem = ~{sp.cd_n, sp.ri_n, sp.dsr_n, sp.cts_n};

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_next = s_reg;
      a = haddr[7:0];
      wd = hwdata[7:0];
      addr_ok = hsel & htrans[1] & hready;
      dir_en = s_reg.fc2[`FC2_MD] & s_reg.fc2[`FC2_TXDIR];
      txe = tx_stat.below_trig |
         (tx_stat.fifo_empty & (~s_reg.fc1[`FC1_TXE] | tx_stat.tsr_empty));
      pend = txe & s_reg.cfg[`IDX_IER][`IER_TXE];

      // Read mux, sampled in the address phase so data stands in the data phase
      rb = 8'h00;
      if (a < `A_DELAY && a[1:0] == 2'h0) begin
         rb = s_reg.cfg[a[5:2]];
      end else begin
         case (a)
            `A_DELAY: rb = s_reg.delay;
            `A_FC2: rb = s_reg.fc2;
            `A_FC1: rb = s_reg.fc1 | {6'h00, s_reg.srst_cnt != 3'h0, 1'b0};
            `A_ISR: rb = pend ? `ISR_TXE : `ISR_RST;
            `A_LSR: rb = {1'b0, s_reg.lsr65, 5'h00};
            `A_MSR: rb = {modem, s_reg.msr_lo};
            `A_TXFILL: rb = tx_fill;
            `A_RXFILL: rb = rx_fill;
            default: rb = 8'h00;
         endcase
      end
      msr_rd = addr_ok & ~hwrite & (a == `A_MSR);
      if (addr_ok & ~hwrite) begin
         s_next.hrdata = {24'h000000, rb};
      end
      s_next.wr_pend = addr_ok & hwrite;
      s_next.wr_addr = a;

      // Register writes in the data phase; status words ignore writes
      if (s_reg.wr_pend) begin
         if (s_reg.wr_addr < `A_DELAY && s_reg.wr_addr[1:0] == 2'h0) begin
            s_next.cfg[s_reg.wr_addr[5:2]] = wd;
         end else begin
            case (s_reg.wr_addr)
               `A_DELAY: s_next.delay = wd;
               `A_FC2: s_next.fc2 = wd & `FC2_MASK;
               `A_FC1: begin
                  s_next.fc1 = wd & `FC1_MASK;
                  if (wd[`FC1_SRST]) begin
                     s_next.srst_cnt = `SRST_CYC;
                  end
               end
               default: s_next.wr_addr = s_reg.wr_addr;
            endcase
         end
      end

      // Direction control; the countdown runs on baud bit ticks
      case (s_reg.dir)
         DIR_RX: begin
            if (tx_stat.tx_pending & ~s_reg.fc2[`FC2_TXOFF]) begin
               s_next.dir = DIR_TX;
            end
         end
         DIR_TX: begin
            if (tx_stat.tx_done) begin
               s_next.dir = DIR_HOLD;
               s_next.cnt = s_reg.delay;
            end
         end
         DIR_HOLD: begin
            if (tx_stat.tx_pending & ~s_reg.fc2[`FC2_TXOFF]) begin
               s_next.dir = DIR_TX;
            end else if (s_reg.cnt == 8'h00) begin
               s_next.dir = DIR_RX;
            end else if (tx_stat.bit_tick) begin
               s_next.cnt = s_reg.cnt - 8'h01;
            end
         end
         default: s_next.dir = DIR_RX;
      endcase
      if (!dir_en) begin
         s_next.dir = DIR_RX;
      end

      // Pins: transmit level while not idle, flipped by the invert bit
      lvl = (s_reg.dir == DIR_RX) ^ s_reg.fc2[`FC2_INV];
      s_next.rts_n = (dir_en & ~s_reg.fc2[`FC2_SEL]) ? lvl
         : ~s_reg.cfg[`IDX_MCR][`MCR_RTS];
      s_next.dtr_n = (dir_en & s_reg.fc2[`FC2_SEL]) ? lvl
         : ~s_reg.cfg[`IDX_MCR][`MCR_DTR];
      // Start bit only after the pin already shows the transmit level
      s_next.tx_go = ~s_reg.fc2[`FC2_TXOFF] & (~dir_en | s_reg.dir == DIR_TX);
      s_next.txd = s_reg.fc2[`FC2_TXOFF] | tx_serial;
      s_next.rx_on = ~s_reg.fc2[`FC2_RXOFF];
      s_next.multidrop = s_reg.fc2[`FC2_MD];
      s_next.flow_ok = s_reg.fc1[`FC1_REMAP] ? modem[1] : modem[0];

      // Sleep; the outer power logic drops sleep_req once woken
      s_next.rx_prev = rx;
      if (!sleep_req) begin
         s_next.sleeping = 1'b0;
      end else if (!s_reg.sleeping) begin
         s_next.sleeping = s_reg.fc1[`FC1_SLP] | rx;
      end else if (s_reg.fc1[`FC1_SLP] ? (rx != s_reg.rx_prev) : ~rx) begin
         s_next.sleeping = 1'b0;
      end

      // Modem change bits: a new change wins over a clearing read
      s_next.msr_hi = modem;
      s_next.primed = 1'b1;
      s_next.msr_lo = (msr_rd ? 4'h0 : s_reg.msr_lo)
         | (s_reg.primed ? (modem ^ s_reg.msr_hi) : 4'h0);

      s_next.lsr65 = {tx_stat.tsr_empty & tx_stat.fifo_empty, tx_stat.fifo_empty};
      s_next.int_o = pend;
      s_next.irq_n_oe = pend;

      // Soft reset holds everything but the bus at the pin-reset value
      if (s_reg.srst_cnt != 3'h0) begin
         s_next = RST_S;
         s_next.srst_cnt = s_reg.srst_cnt - 3'h1;
         s_next.hrdata = (addr_ok & ~hwrite) ? {24'h000000, rb} : s_reg.hrdata;
         s_next.wr_pend = addr_ok & hwrite;
         s_next.wr_addr = a;
      end
      s_next.uart_rst_n = (s_next.srst_cnt == 3'h0);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= RST_S;
      end else begin
         s_reg <= s_next;
      end
   end

   // ****************************************
   // Outputs, straight from flops except hresp and irq_n_o, tied low
   // ****************************************
   assign hrdata = s_reg.hrdata;
   assign hreadyout = s_reg.hreadyout;
   assign hresp = s_reg.irq_n_oe & 1'b0;
   assign txd = s_reg.txd;
   assign rts_n = s_reg.rts_n;
   assign dtr_n = s_reg.dtr_n;
   assign int_o = s_reg.int_o;
   assign irq_n_o = s_reg.int_o & 1'b0;
   assign irq_n_oe = s_reg.irq_n_oe;
   assign tx_go = s_reg.tx_go;
   assign rx_on = s_reg.rx_on;
   assign multidrop = s_reg.multidrop;
   assign flow_ok = s_reg.flow_ok;
   assign sleeping = s_reg.sleeping;
   assign uart_rst_n = s_reg.uart_rst_n;

   // ****************************************
   // Assertions
   // ****************************************
   logic srst_on;
   assign srst_on = s_reg.srst_cnt != 3'h0;

   a_srst_length: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(uart_rst_n) |-> !uart_rst_n [*4] ##1 uart_rst_n)
      else $error("soft reset not four cycles");

   a_srst_state: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(uart_rst_n) |-> s_reg.fc2 == 8'h00 && s_reg.delay == 8'h00 && txd && rts_n)
      else $error("soft reset state differs");

   a_dir_load: assert property (@(posedge hclk) disable iff (!hresetn)
      s_reg.dir == DIR_TX && tx_stat.tx_done && dir_en && !srst_on
      |=> s_reg.dir == DIR_HOLD && s_reg.cnt == $past(s_reg.delay))
      else $error("turn-around count not loaded");

   a_dir_tick: assert property (@(posedge hclk) disable iff (!hresetn)
      s_reg.dir == DIR_HOLD && s_reg.cnt != 8'h00 && tx_stat.bit_tick && dir_en
      && !tx_stat.tx_pending && !srst_on |=> s_reg.cnt == $past(s_reg.cnt) - 8'h01)
      else $error("count not stepped on bit tick");

   a_dir_release: assert property (@(posedge hclk) disable iff (!hresetn)
      s_reg.dir == DIR_HOLD && s_reg.cnt == 8'h00 && !tx_stat.tx_pending && !srst_on
      && !s_reg.fc2[`FC2_SEL]
      |=> s_reg.dir == DIR_RX ##1 rts_n == (!$past(s_reg.fc2[`FC2_INV]) || !dir_en))
      else $error("direction not returned to receive");

   a_dir_level: assert property (@(posedge hclk) disable iff (!hresetn)
      s_reg.dir == DIR_TX && dir_en && !s_reg.fc2[`FC2_SEL] && !srst_on
      |=> rts_n == $past(s_reg.fc2[`FC2_INV]) && dtr_n == !$past(s_reg.cfg[`IDX_MCR][`MCR_DTR]))
      else $error("transmit level wrong");

   a_dir_free: assert property (@(posedge hclk) disable iff (!hresetn)
      !s_reg.fc2[`FC2_TXDIR] && !srst_on |=> rts_n == !$past(s_reg.cfg[`IDX_MCR][`MCR_RTS]))
      else $error("pin driven without control bit");

   a_tx_off: assert property (@(posedge hclk) disable iff (!hresetn)
      s_reg.fc2[`FC2_TXOFF] |=> txd && !tx_go)
      else $error("disabled transmitter active");

   a_rx_off: assert property (@(posedge hclk) disable iff (!hresetn)
      s_reg.fc2[`FC2_RXOFF] && !srst_on |=> !rx_on)
      else $error("disabled receiver active");

   a_sleep_wake: assert property (@(posedge hclk) disable iff (!hresetn)
      sleeping && !s_reg.fc1[`FC1_SLP] && !rx && !srst_on |=> !sleeping)
      else $error("no wake on low receive");

   a_irq_mode: assert property (@(posedge hclk) disable iff (!hresetn)
      s_reg.fc1[`FC1_TXE] && !tx_stat.tsr_empty && !tx_stat.below_trig && !srst_on
      |=> !int_o)
      else $error("empty interrupt before shifter drained");

   a_flow_map: assert property (@(posedge hclk) disable iff (!hresetn)
      s_reg.fc1[`FC1_REMAP] && !srst_on |=> flow_ok == !$past(sp.dsr_n))
      else $error("flow control not remapped");

   c_turnaround: cover property (@(posedge hclk) disable iff (!hresetn)
      s_reg.dir == DIR_HOLD && s_reg.cnt == 8'h02 ##[1:200] s_reg.dir == DIR_RX);
   c_restart: cover property (@(posedge hclk) disable iff (!hresetn)
      s_reg.dir == DIR_HOLD ##1 s_reg.dir == DIR_TX);
   c_soft_reset: cover property (@(posedge hclk) disable iff (!hresetn) $rose(uart_rst_n));
   c_sleep: cover property (@(posedge hclk) disable iff (!hresetn) $fell(sleeping));
endmodule
`default_nettype wire

// [sim/tx_side_model.sv]
// Behavioural transmit side: FIFO count, shifter of ten bits and a free baud tick.
// Assumes go is the controller's tx_go and add a one-cycle request from the bench.
`timescale 1ns/1ns
`default_nettype none
module tx_side_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic add,
   output uart_feature_pkg::tx_stat_t st,
   output logic ser
);
   import uart_feature_pkg::*;
   // ****************************************
   // Shifter
   // ****************************************
   logic [2:0] pre;
   logic [2:0] pend;
   logic [3:0] nbit;
   logic [9:0] sh;
   logic done;
   logic tick;
   logic start;
   // A bit time is eight clocks, so countdowns stay short
   assign tick = (pre == 3'h7);
   assign start = go && (pend != 3'h0) && (nbit == 4'h0);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre <= 3'h0;
         pend <= 3'h0;
         nbit <= 4'h0;
         sh <= 10'h000;
         done <= 1'b0;
      end else begin
         pre <= pre + 3'h1;
         done <= 1'b0;
         pend <= pend + {2'h0, add} - {2'h0, start};
         if (start) begin
            nbit <= 4'hA;
            sh <= 10'h2A6;
         end else if (tick && nbit != 4'h0) begin
            nbit <= nbit - 4'h1;
            sh <= {~sh[0], sh[9:1]};
            done <= (nbit == 4'h1);
         end
      end
   end
   // Idle line is high; a frame changes level often so a stale value shows
   assign ser = (nbit != 4'h0) ? sh[0] : 1'b1;
   assign st = '{tx_pending: pend != 3'h0, tx_done: done, bit_tick: tick,
                 tsr_empty: nbit == 4'h0, fifo_empty: pend == 3'h0, below_trig: 1'b0};
endmodule
`default_nettype wire

// [sim/tb_uart_feature_ctrl.sv]
// Self-checking bench for the feature controller over AHB-Lite.
// Assumes the transmit side model and the register header on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "uart_feature_regs.svh"
module tb_uart_feature_ctrl;
   import uart_feature_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0, add = 1'b0, sleep_req = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic hreadyout, txd, rts_n, dtr_n, int_o, irq_n_oe, tx_go, rx_on;
   logic multidrop, flow_ok, sleeping, urst_n, ser, sel, inv, w;
   pins_t pins = 5'h10;
   tx_stat_t stat;
   int mismatches = 0, checks = 0, n;
   always #2 hclk = ~hclk;
   uart_feature_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .pins(pins), .tx_stat(stat),
      .tx_serial(ser), .sleep_req(sleep_req), .tx_fill(8'h00), .rx_fill(8'h00), .txd(txd),
      .rts_n(rts_n), .dtr_n(dtr_n), .int_o(int_o), .irq_n_o(), .irq_n_oe(irq_n_oe),
      .tx_go(tx_go), .rx_on(rx_on), .multidrop(multidrop), .flow_ok(flow_ok),
      .sleeping(sleeping), .uart_rst_n(urst_n));
   tx_side_model partner (.clk(hclk), .rst_n(urst_n), .go(tx_go), .add(add), .st(stat),
      .ser(ser));
   // ****************************************
   // Bus and check tasks
   // ****************************************
   task automatic wrap_up();
      if (mismatches == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 8'h00);
      chk(rd, e);
   endtask
   task automatic send();
      @(posedge hclk);
      add <= 1'b1;
      @(posedge hclk);
      add <= 1'b0;
      for (n = 0; n < 40 && stat.tsr_empty !== 1'b0; n++) @(posedge hclk);
   endtask
   task automatic wait_done();
      for (n = 0; n < 200 && stat.tx_done !== 1'b1; n++) @(posedge hclk);
   endtask
   task automatic seen_awake();
      w = 1'b0;
      for (n = 0; n < 8; n++) begin
         @(posedge hclk);
         if (sleeping === 1'b0) w = 1'b1;
      end
   endtask
   task automatic rst_chk();
      logic [7:0] e;
      for (int a = 0; a <= 8'h48; a += 4) begin
         e = (a == 8'h38) ? `ISR_RST : (a == 8'h3C) ? {1'b0, `LSR_RST, 5'h0} : 8'h00;
         if (a == 8'h40) e = 8'hF0;
         rdchk(a[7:0], {24'h0, e});
      end
      rdchk(8'h4C, 32'h0);
      chk({28'h0, txd, rts_n, dtr_n, int_o}, 32'hE);
      chk({31'h0, irq_n_oe}, 32'h0);
   endtask
   function automatic logic dpin(input logic s);
      return s ? dtr_n : rts_n;
   endfunction
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      rst_chk();
      bus(1'b1, `A_FC2, 8'hFF);
      rdchk(`A_FC2, {24'h0, `FC2_MASK});
      chk({30'h0, rx_on, multidrop}, 32'h1);
      bus(1'b1, `A_FC1, 8'hFD);
      rdchk(`A_FC1, {24'h0, `FC1_MASK});
      bus(1'b1, `A_FC1, 8'h00);
      bus(1'b1, `A_FC2, 8'h04);
      send();
      chk({30'h0, tx_go, txd}, 32'h1);
      bus(1'b1, `A_FC2, 8'h00);
      chk({30'h0, rx_on, multidrop}, 32'h2);
      for (n = 0; n < 40 && stat.tsr_empty !== 1'b0; n++) @(posedge hclk);
      chk({31'h0, stat.tsr_empty}, 32'h0);
      wait_done();
      pins.cts_n <= 1'b1;
      repeat (5) @(posedge hclk);
      chk({31'h0, flow_ok}, 32'h0);
      bus(1'b1, `A_FC1, 8'h04);
      repeat (3) @(posedge hclk);
      chk({31'h0, flow_ok}, 32'h1);
      pins.dsr_n <= 1'b1;
      repeat (5) @(posedge hclk);
      chk({31'h0, flow_ok}, 32'h0);
      bus(1'b1, `A_FC1, 8'h00);
      // Modem pins back to their starting low level, receive line low in one step
      pins <= 5'h00;
      sleep_req <= 1'b1;
      repeat (6) @(posedge hclk);
      chk({31'h0, sleeping}, 32'h0);
      pins.rx <= 1'b1;
      repeat (6) @(posedge hclk);
      chk({31'h0, sleeping}, 32'h1);
      pins.rx <= 1'b0;
      seen_awake();
      chk({31'h0, w}, 32'h1);
      bus(1'b1, `A_FC1, 8'h10);
      repeat (6) @(posedge hclk);
      chk({31'h0, sleeping}, 32'h1);
      pins.rx <= 1'b1;
      seen_awake();
      chk({31'h0, w}, 32'h1);
      sleep_req <= 1'b0;
      bus(1'b1, `A_IER, 8'h02);
      bus(1'b1, `A_FC1, 8'h01);
      chk({31'h0, int_o}, 32'h1);
      send();
      repeat (2) @(posedge hclk);
      chk({31'h0, int_o}, 32'h0);
      wait_done();
      repeat (3) @(posedge hclk);
      chk({31'h0, int_o}, 32'h1);
      bus(1'b1, `A_FC1, 8'h00);
      send();
      repeat (2) @(posedge hclk);
      chk({31'h0, int_o}, 32'h1);
      rdchk(`A_ISR, {24'h0, `ISR_TXE});
      wait_done();
      bus(1'b1, `A_IER, 8'h00);
      bus(1'b1, `A_FC2, 8'h01);
      send();
      chk({30'h0, rts_n, dtr_n}, 32'h3);
      wait_done();
      // Each pin choice and polarity, with a growing turn-around delay
      for (int i = 0; i < 4; i++) begin
         sel = i[0];
         inv = i[1];
         bus(1'b1, `A_DELAY, 8'(i * 2));
         bus(1'b1, `A_FC2, {2'h0, inv, 1'b1, sel, 3'h1});
         repeat (3) @(posedge hclk);
         chk({31'h0, dpin(sel)}, {31'h0, ~inv});
         @(posedge hclk);
         add <= 1'b1;
         @(posedge hclk);
         add <= 1'b0;
         for (n = 0; n < 40 && tx_go !== 1'b1; n++) @(posedge hclk);
         chk({31'h0, dpin(sel)}, {31'h0, inv});
         chk({31'h0, dpin(~sel)}, 32'h1);
         wait_done();
         for (n = 0; n < 200 && dpin(sel) === inv; n++) @(posedge hclk);
         chk((n >= i * 16 - 8 && n <= i * 16 + 6) ? i * 16 : n, i * 16);
      end
      for (int a = 0; a <= 8'h4C; a += 4) begin
         if (a != 8'h34) bus(1'b1, a[7:0], 8'hA5);
      end
      rdchk(`A_IER, 32'hA5);
      bus(1'b1, `A_FC1, 8'h02);
      w = 1'b0;
      for (int k = 0; k < 12; k++) begin
         @(posedge hclk);
         if (urst_n === 1'b0) w = 1'b1;
         if (urst_n === 1'b0) n++;
         if (k == 0) n = (urst_n === 1'b0) ? 1 : 0;
      end
      chk(n, {29'h0, `SRST_CYC});
      rst_chk();
      wrap_up();
   end
   initial begin
      #100000;
      mismatches++;
      wrap_up();
   end
endmodule
`default_nettype wire
